//--- bench/microcode_skip_and_entry_mapper_test.sv
`include "mssem_map.vh"
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module microcode_skip_and_entry_mapper_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, reset_n, macro_on_b, a_addressed, b_addressed, carry_out_n;
    logic cpu_flag, overflow_n, next_phase_valid, subroutine_jump_n;
    logic repeat_active, skip_taken, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [3:0] skip_code, phase, s_axi_wstrb;
    logic [1:0] special_code, next_phase_id, s_axi_bresp, s_axi_rresp;
    logic [4:0] macro_op, repeat_counter;
    logic [15:0] tbus, alu_out, sbus;
    logic [8:0] micro_address;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int n_mismatch = 0, n_checks = 0, cycles = 0;
    mssem_sequencer dut (.*);
    mssem_rom_model rom (.clock(clock), .skip_code(skip_code), .special_code(special_code));
    always #10 clock = ~clock;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task complete_run();
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clock);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK("rresp", er, s_axi_rresp)
        `CHK("rdata", ed, s_axi_rdata)
    endtask
    task dp(input logic a, b, cn, fl, ov, input logic [15:0] t, al);
        @(posedge clock);
        {a_addressed, b_addressed, carry_out_n, cpu_flag, overflow_n} <= {a, b, cn, fl, ov};
        {tbus, alu_out} <= {t, al};
    endtask
    // one microword, then back to nop; address step and skip judged
    task step(input logic [3:0] sk, input logic [1:0] sp, input logic es, input logic [8:0] dl);
        logic [8:0] a0;
        @(posedge clock);
        rom.put(sk, sp);
        #1 a0 = micro_address;
        @(posedge clock);
        rom.put(`MSSEM_SK_NOP, `MSSEM_SP_NONE);
        #1;
        `CHK("address", a0 + dl, micro_address)
        `CHK("skip", es, skip_taken)
    endtask
    task t_regs();
        rd(12'h000, 32'h0, `MSSEM_AXI_OKAY);
        rd(12'h004, 32'h440, `MSSEM_AXI_OKAY);
        // sequencer frozen until enabled, so the address is still zero
        rd(12'h008, 32'h0, `MSSEM_AXI_OKAY);
        rd(12'h00c, 32'h0, `MSSEM_AXI_SLVERR);
        wr(12'h010, 32'h1, `MSSEM_AXI_SLVERR);
        rd(12'h000, 32'h0, `MSSEM_AXI_OKAY);
        wr(12'h000, 32'h1, `MSSEM_AXI_OKAY);
        rd(12'h000, 32'h1, `MSSEM_AXI_OKAY);
    endtask
    // every test code except the two counter tests, plain and reversed, against two opposite states
    task t_skips();
        logic [15:0] m1, m2;
        logic e;
        m1 = 16'h9b46;
        m2 = 16'hc400;
        for (int r = 0; r < 2; r++) begin
            for (int c = 1; c < 16; c++) begin
                if (!(c inside {3, 4, 5, 7, 13})) begin
                    dp(0, 1, 0, 1, 0, 16'h0002, 16'h8001);
                    e = m1[c] ^ r[0];
                    step(c[3:0], r[1:0], e, e ? 9'h002 : 9'h001);
                    dp(0, 0, 1, 0, 1, 16'h0000, 16'h7ffe);
                    e = m2[c] ^ r[0];
                    step(c[3:0], r[1:0], e, e ? 9'h002 : 9'h001);
                end
            end
        end
        dp(1, 0, 1, 0, 1, 16'h8001, 16'h8001);
        step(`MSSEM_SK_AB_ADDRESSED, 2'h0, 1'b1, 9'h002);
        step(`MSSEM_SK_TBUS_NONZERO_MID, 2'h0, 1'b0, 9'h001);
        wr(12'h000, 32'h3, `MSSEM_AXI_OKAY);
        step(`MSSEM_SK_PROTECT_OK, 2'h0, 1'b0, 9'h001);
        dp(0, 0, 1, 0, 1, 16'h8001, 16'h7ffe);
        step(`MSSEM_SK_PROTECT_OK, 2'h0, 1'b0, 9'h001);
        dp(0, 0, 1, 0, 1, 16'h8001, 16'h8001);
        step(`MSSEM_SK_PROTECT_OK, 2'h0, 1'b1, 9'h002);
        wr(12'h000, 32'h1, `MSSEM_AXI_OKAY);
    endtask
    task t_counter();
        @(posedge clock);
        sbus <= 16'hfff7;
        step(`MSSEM_SK_NOP, `MSSEM_SP_COUNTER_LOAD, 1'b0, 9'h001);
        `CHK("counter", 5'h07, repeat_counter)
        step(`MSSEM_SK_COUNTER_FULL, 2'h0, 1'b0, 9'h001);
        step(`MSSEM_SK_COUNTER_INC, 2'h0, 1'b0, 9'h001);
        `CHK("counter", 5'h08, repeat_counter)
        @(posedge clock);
        sbus <= 16'h000f;
        step(`MSSEM_SK_NOP, `MSSEM_SP_COUNTER_LOAD, 1'b0, 9'h001);
        step(`MSSEM_SK_COUNTER_FULL, 2'h0, 1'b1, 9'h002);
        step(`MSSEM_SK_COUNTER_FULL_INC, 2'h0, 1'b1, 9'h002);
        `CHK("counter", 5'h10, repeat_counter)
        repeat (15) step(`MSSEM_SK_COUNTER_INC, 2'h0, 1'b0, 9'h001);
        step(`MSSEM_SK_COUNTER_FULL, 2'h0, 1'b1, 9'h002);
        `CHK("counter", 5'h1f, repeat_counter)
    endtask
    task t_repeat();
        dp(0, 0, 1, 0, 1, 16'h0000, 16'h0000);
        step(`MSSEM_SK_REPEAT_NEXT, 2'h0, 1'b0, 9'h001);
        `CHK("repeat", 1'b1, repeat_active)
        step(`MSSEM_SK_ODD, 2'h0, 1'b0, 9'h000);
        dp(0, 0, 1, 0, 1, 16'h0000, 16'h0001);
        step(`MSSEM_SK_ODD, 2'h0, 1'b1, 9'h002);
        `CHK("repeat", 1'b0, repeat_active)
    endtask
    task phase_end(input logic [4:0] op, input logic b,
        input logic [8:0] ea, input logic [1:0] id);
        @(posedge clock);
        {macro_op, macro_on_b, next_phase_valid, next_phase_id} <= {op, b, 1'b1, id};
        rom.put(`MSSEM_SK_END_OF_PHASE, `MSSEM_SP_NONE);
        @(posedge clock);
        rom.put(`MSSEM_SK_NOP, `MSSEM_SP_NONE);
        next_phase_valid <= 1'b0;
        #1;
        `CHK("entry", ea, micro_address)
        `CHK("phase", 4'h1 << id, phase)
        `CHK("subroutine_jump_n", 1'b0, subroutine_jump_n)
    endtask
    task t_entry();
        logic [8:0] ea [21];
        ea = '{9'h048, 9'h050, 9'h058, 9'h054, 9'h068, 9'h078, 9'h064, 9'h04c,
            9'h074, 9'h05c, 9'h040, 9'h088, 9'h090, 9'h0c8, 9'h0d0, 9'h081,
            9'h0a1, 9'h082, 9'h0a2, 9'h084, 9'h0a4};
        for (int i = 0; i < 21; i++)
            phase_end(i[4:0], 1'b0, ea[i], i[1:0]);
        phase_end(`MSSEM_OP_SHIFT_ROTATE, 1'b1, 9'h044, 2'h3);
        // an unlisted class falls back to address zero
        phase_end(5'h1f, 1'b0, 9'h000, 2'h2);
    endtask
    initial begin
        {clock, reset_n, macro_op, macro_on_b, a_addressed, b_addressed} = 0;
        {cpu_flag, next_phase_valid, next_phase_id, tbus, alu_out, sbus} = 0;
        {carry_out_n, overflow_n, s_axi_wstrb} = 6'h3f;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        t_regs();
        t_skips();
        t_counter();
        t_repeat();
        t_entry();
        complete_run();
    end
endmodule // microcode_skip_and_entry_mapper_test
`default_nettype wire

//--- bench/mssem_properties.sv
`include "mssem_map.vh"
`default_nettype none
module mssem_properties (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [3:0] skip_code,
    input wire logic [1:0] special_code,
    input wire logic [15:0] tbus,
    input wire logic [15:0] alu_out,
    input wire logic [15:0] sbus,
    input wire logic next_phase_valid,
    input wire logic [1:0] next_phase_id,
    input wire logic [8:0] micro_address,
    input wire logic [3:0] phase,
    input wire logic subroutine_jump_n,
    input wire logic repeat_active,
    input wire logic [4:0] repeat_counter,
    input wire logic skip_taken,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en;
    logic [11:0] wa;
    logic [31:0] wd;
    // run enable mirrored from finished control writes; it lags the
    // design, which delays both when the checks arm and when they disarm
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            en <= 1'b0;
            wa <= 12'h000;
            wd <= 32'h00000000;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                wd <= s_axi_wdata;
            if (s_axi_bvalid && s_axi_bready && wa == 12'h000
                && s_axi_bresp == 2'h0)
                en <= wd[0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence plain(logic [3:0] c);
        en && skip_code == c && special_code == `MSSEM_SP_NONE && !repeat_active;
    endsequence
    sequence repeat_start;
        plain(`MSSEM_SK_REPEAT_NEXT);
    endsequence
    uncond_skip_a: assert property (
        plain(`MSSEM_SK_UNCONDITIONAL) |=> skip_taken)
        else $error("unconditional code did not skip");
    nop_quiet_a: assert property (
        plain(`MSSEM_SK_NOP) |=> !skip_taken
            && $stable(repeat_counter) && $stable(phase))
        else $error("nop code had a side effect");
    odd_skip_a: assert property (
        plain(`MSSEM_SK_ODD) |=> skip_taken == $past(alu_out[0]))
        else $error("odd test wrong");
    tbus_zero_a: assert property (
        plain(`MSSEM_SK_TBUS_ZERO)
            |=> skip_taken == ($past(tbus) == 16'h0000))
        else $error("zero test wrong");
    counter_inc_a: assert property (
        plain(`MSSEM_SK_COUNTER_INC) |=> !skip_taken
            && repeat_counter == $past(repeat_counter) + 5'h01)
        else $error("counter increment wrong");
    counter_load_a: assert property (
        en && special_code == `MSSEM_SP_COUNTER_LOAD
            |=> repeat_counter == {1'b0, $past(sbus[3:0])})
        else $error("counter load wrong");
    reverse_sense_a: assert property (
        en && !repeat_active && skip_code == `MSSEM_SK_NEGATIVE
            && special_code == `MSSEM_SP_REVERSE_SKIP
            |=> skip_taken == !$past(alu_out[15]))
        else $error("reversed sense wrong");
    // end of phase drives the active-low subroutine flop to zero
    phase_set_a: assert property (
        en && skip_code == `MSSEM_SK_END_OF_PHASE && next_phase_valid
            |=> !subroutine_jump_n
            && phase == 4'h1 << $past(next_phase_id))
        else $error("end of phase flags wrong");
    step_size_a: assert property (
        en && !repeat_active && skip_code != `MSSEM_SK_END_OF_PHASE
            |=> micro_address
            == $past(micro_address) + (skip_taken ? 9'h002 : 9'h001))
        else $error("address step wrong");
    repeat_entry_a: assert property (
        repeat_start |=> repeat_active
            && micro_address == $past(micro_address) + 9'h001)
        else $error("repeat not entered");
    // a repeated word holds the address until it skips
    repeat_hold_a: assert property (
        en && repeat_active && skip_code != `MSSEM_SK_END_OF_PHASE
            |=> skip_taken ? !repeat_active
            : micro_address == $past(micro_address))
        else $error("repeat did not hold");
endmodule // mssem_properties
bind mssem_sequencer mssem_properties props (.*);
`default_nettype wire

//--- bench/mssem_rom_model.sv
`include "mssem_map.vh"
`default_nettype none
// microword source standing in for the microprogram store: presents the
// skip and special fields; the bench chooses each word, idle word is a nop
module mssem_rom_model (
    input wire logic clock,
    output logic [3:0] skip_code,
    output logic [1:0] special_code
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        skip_code = `MSSEM_SK_NOP;
        special_code = `MSSEM_SP_NONE;
    end
    // called at a rising edge only, so the word changes just after it
    task put(input logic [3:0] sk, input logic [1:0] sp);
        skip_code <= sk;
        special_code <= sp;
    endtask
endmodule // mssem_rom_model
`default_nettype wire

//--- rtl/mssem_sequencer.v
// What this block does
// - addressable test skips when A- or B-addressed flip-flop is set
// - carry-out test skips when active-low carry-out is low
// - counter tests skip on low four bits all ones; inc form advances
// - plain counter-increment code advances repeat counter, no skip
// - end of phase: mapper entry, phase set if next_phase_valid, subroutine_jump_n cleared
// - flag test skips when CPU flag flip-flop is set
// - mid T-bus test skips when any of T-bus bits 1..14 is one
// - negative test skips when ALU bit 15 is one
// - protect test skips if A/B unaddressed and protection off or bit 15 set
// - odd test skips when ALU bit 0 is one
// - overflow test skips when active-low overflow flip-flop is low
// - repeat code sets repeat flag, reruns next word until its skip holds
// - zero test skips when all T-bus bits are zero
// - unconditional code skips unless reverse sense is set
// - reverse-skip-sense special code inverts the tested skip outcome
// - counter-load special code loads repeat counter from S-bus bits 0..3
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`include "mssem_map.vh"
`default_nettype none

module mssem_sequencer #(
    parameter ADDR_WIDTH = 9,
    parameter COUNT_WIDTH = 5
) (
    input wire clock,
    input wire reset_n,
    input wire [3:0] skip_code,
    input wire [1:0] special_code,
    input wire [4:0] macro_op,
    input wire macro_on_b,
    input wire a_addressed,
    input wire b_addressed,
    input wire carry_out_n,
    input wire cpu_flag,
    input wire overflow_n,
    input wire [15:0] tbus,
    input wire [15:0] alu_out,
    input wire [15:0] sbus,
    input wire next_phase_valid,
    input wire [1:0] next_phase_id,
    output reg [ADDR_WIDTH-1:0] micro_address,
    output reg [3:0] phase,
    output reg subroutine_jump_n,
    output reg repeat_active,
    output reg [COUNT_WIDTH-1:0] repeat_counter,
    output reg skip_taken,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [11:0] s_axi_araddr,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp
);

    // entry address lookup, shared by end-of-phase jumps
    function [8:0] entry_of;
        input [4:0] op;
        input on_b;
        begin
            case (op)
                `MSSEM_OP_AND: entry_of = `MSSEM_EA_AND;
                `MSSEM_OP_XOR: entry_of = `MSSEM_EA_XOR;
                `MSSEM_OP_IOR: entry_of = `MSSEM_EA_IOR;
                `MSSEM_OP_JUMP: entry_of = `MSSEM_EA_JUMP;
                `MSSEM_OP_SUBROUTINE_JUMP:
                    entry_of = `MSSEM_EA_SUBROUTINE_JUMP;
                `MSSEM_OP_INCREMENT_SKIP_ZERO:
                    entry_of = `MSSEM_EA_INCREMENT_SKIP_ZERO;
                `MSSEM_OP_ADD_TO_ACCUMULATOR:
                    entry_of = `MSSEM_EA_ADD_TO_ACCUMULATOR;
                `MSSEM_OP_COMPARE_ACCUMULATOR:
                    entry_of = `MSSEM_EA_COMPARE_ACCUMULATOR;
                `MSSEM_OP_LOAD_ACCUMULATOR:
                    entry_of = `MSSEM_EA_LOAD_ACCUMULATOR;
                `MSSEM_OP_STORE_ACCUMULATOR:
                    entry_of = `MSSEM_EA_STORE_ACCUMULATOR;
                `MSSEM_OP_SHIFT_ROTATE:
                    entry_of = on_b ? `MSSEM_EA_SHIFT_ROTATE_B
                        : `MSSEM_EA_SHIFT_ROTATE_A;
                `MSSEM_OP_MULTIPLY: entry_of = `MSSEM_EA_MULTIPLY;
                `MSSEM_OP_DIVIDE: entry_of = `MSSEM_EA_DIVIDE;
                `MSSEM_OP_DOUBLE_LOAD:
                    entry_of = `MSSEM_EA_DOUBLE_LOAD;
                `MSSEM_OP_DOUBLE_STORE:
                    entry_of = `MSSEM_EA_DOUBLE_STORE;
                `MSSEM_OP_ARITH_SHIFT_LEFT:
                    entry_of = `MSSEM_EA_ARITH_SHIFT_LEFT;
                `MSSEM_OP_ARITH_SHIFT_RIGHT:
                    entry_of = `MSSEM_EA_ARITH_SHIFT_RIGHT;
                `MSSEM_OP_LOGIC_SHIFT_LEFT:
                    entry_of = `MSSEM_EA_LOGIC_SHIFT_LEFT;
                `MSSEM_OP_LOGIC_SHIFT_RIGHT:
                    entry_of = `MSSEM_EA_LOGIC_SHIFT_RIGHT;
                `MSSEM_OP_ROTATE_LEFT_LONG:
                    entry_of = `MSSEM_EA_ROTATE_LEFT_LONG;
                `MSSEM_OP_ROTATE_RIGHT_LONG:
                    entry_of = `MSSEM_EA_ROTATE_RIGHT_LONG;
                default: entry_of = `MSSEM_EA_DEFAULT;
            endcase
        end
    endfunction

    reg [1:0] control;
    wire run_enable = control[`MSSEM_CTL_ENABLE];
    wire protect_enable = control[`MSSEM_CTL_PROTECT];

    // raw condition of the skip field
    reg raw_skip;
    always @* begin
        case (skip_code)
            `MSSEM_SK_AB_ADDRESSED:
                raw_skip = a_addressed | b_addressed;
            `MSSEM_SK_CARRY_OUT: raw_skip = ~carry_out_n;
            `MSSEM_SK_COUNTER_FULL,
            `MSSEM_SK_COUNTER_FULL_INC:
                raw_skip = &repeat_counter[3:0];
            `MSSEM_SK_CPU_FLAG: raw_skip = cpu_flag;
            `MSSEM_SK_TBUS_NONZERO_MID: raw_skip = |tbus[14:1];
            `MSSEM_SK_NEGATIVE: raw_skip = alu_out[15];
            `MSSEM_SK_PROTECT_OK:
                raw_skip = ~(a_addressed | b_addressed)
                    & (~protect_enable | alu_out[15]);
            `MSSEM_SK_ODD: raw_skip = alu_out[0];
            `MSSEM_SK_OVERFLOW: raw_skip = ~overflow_n;
            `MSSEM_SK_TBUS_ZERO: raw_skip = ~|tbus;
            `MSSEM_SK_UNCONDITIONAL: raw_skip = 1'b1;
            default: raw_skip = 1'b0;
        endcase
    end

    // codes that test nothing are not inverted, so reverse sense
    // cannot turn a no-op or counter bump into a skip
    wire is_test = (skip_code != `MSSEM_SK_NOP) &&
        (skip_code != `MSSEM_SK_COUNTER_INC) &&
        (skip_code != `MSSEM_SK_END_OF_PHASE) &&
        (skip_code != `MSSEM_SK_REPEAT_NEXT);
    wire reverse = special_code == `MSSEM_SP_REVERSE_SKIP;
    wire next_skip = is_test & (raw_skip ^ reverse);

    // sequencing: address, phase, counter, repeat
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            micro_address <= `MSSEM_RST_ADDRESS;
            phase <= 4'h1;
            subroutine_jump_n <= 1'b1;
            repeat_active <= 1'b0;
            repeat_counter <= `MSSEM_RST_COUNTER;
            skip_taken <= 1'b0;
        end else if (run_enable) begin
            skip_taken <= next_skip;
            if (skip_code == `MSSEM_SK_END_OF_PHASE) begin
                micro_address <= entry_of(macro_op, macro_on_b);
                if (next_phase_valid)
                    phase <= 4'h1 << next_phase_id;
                // clearing the active-low flop drives it to zero
                subroutine_jump_n <= 1'b0;
            end else if (skip_code == `MSSEM_SK_REPEAT_NEXT) begin
                repeat_active <= 1'b1;
                micro_address <= micro_address + 1'b1;
            end else if (repeat_active && !next_skip) begin
                // hold on the repeated word until its own test passes
                micro_address <= micro_address;
            end else if (next_skip) begin
                repeat_active <= 1'b0;
                micro_address <= micro_address + 2'd2;
            end else begin
                repeat_active <= 1'b0;
                micro_address <= micro_address + 1'b1;
            end
            if (special_code == `MSSEM_SP_COUNTER_LOAD)
                repeat_counter <= {1'b0, sbus[3:0]};
            else if (skip_code == `MSSEM_SK_COUNTER_FULL_INC ||
                skip_code == `MSSEM_SK_COUNTER_INC)
                repeat_counter <= repeat_counter + 1'b1;
        end
    end

    // axi4-lite slave: single outstanding write and read
    reg aw_held;
    reg w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MSSEM_AXI_OKAY;
            control <= `MSSEM_RST_CONTROL;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid
                & ~s_axi_bvalid;
            s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid
                & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == `MSSEM_REG_CONTROL) begin
                    s_axi_bresp <= `MSSEM_AXI_OKAY;
                    if (w_strb[0])
                        control <= w_data[1:0];
                end else if (aw_addr == `MSSEM_REG_STATUS ||
                    aw_addr == `MSSEM_REG_ADDRESS)
                    s_axi_bresp <= `MSSEM_AXI_OKAY; // read-only, ignored
                else
                    s_axi_bresp <= `MSSEM_AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read channel; status shows live sequencer state
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MSSEM_AXI_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & s_axi_arvalid
                & ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `MSSEM_AXI_OKAY;
                case (s_axi_araddr)
                    `MSSEM_REG_CONTROL:
                        s_axi_rdata <= {30'h00000000, control};
                    `MSSEM_REG_STATUS:
                        s_axi_rdata <= {19'h00000, skip_taken,
                            repeat_active, subroutine_jump_n, phase,
                            {(6-COUNT_WIDTH){1'b0}}, repeat_counter};
                    `MSSEM_REG_ADDRESS:
                        s_axi_rdata <= {{(32-ADDR_WIDTH){1'b0}},
                            micro_address};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `MSSEM_AXI_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // mssem_sequencer
`default_nettype wire

//--- shared/mssem_map.vh
`ifndef MSSEM_MAP_VH
`define MSSEM_MAP_VH
// skip field codes (4 bits)
`define MSSEM_SK_NOP 4'h0
`define MSSEM_SK_AB_ADDRESSED 4'h1
`define MSSEM_SK_CARRY_OUT 4'h2
`define MSSEM_SK_COUNTER_FULL 4'h3
`define MSSEM_SK_COUNTER_FULL_INC 4'h4
`define MSSEM_SK_END_OF_PHASE 4'h5
`define MSSEM_SK_CPU_FLAG 4'h6
`define MSSEM_SK_COUNTER_INC 4'h7
`define MSSEM_SK_TBUS_NONZERO_MID 4'h8
`define MSSEM_SK_NEGATIVE 4'h9
`define MSSEM_SK_PROTECT_OK 4'ha
`define MSSEM_SK_ODD 4'hb
`define MSSEM_SK_OVERFLOW 4'hc
`define MSSEM_SK_REPEAT_NEXT 4'hd
`define MSSEM_SK_TBUS_ZERO 4'he
`define MSSEM_SK_UNCONDITIONAL 4'hf
// special field codes (2 bits, only those this block uses)
`define MSSEM_SP_NONE 2'h0
`define MSSEM_SP_REVERSE_SKIP 2'h1
`define MSSEM_SP_COUNTER_LOAD 2'h2
// macro instruction classes presented by the decoder
`define MSSEM_OP_AND 5'h00
`define MSSEM_OP_XOR 5'h01
`define MSSEM_OP_IOR 5'h02
`define MSSEM_OP_JUMP 5'h03
`define MSSEM_OP_SUBROUTINE_JUMP 5'h04
`define MSSEM_OP_INCREMENT_SKIP_ZERO 5'h05
`define MSSEM_OP_ADD_TO_ACCUMULATOR 5'h06
`define MSSEM_OP_COMPARE_ACCUMULATOR 5'h07
`define MSSEM_OP_LOAD_ACCUMULATOR 5'h08
`define MSSEM_OP_STORE_ACCUMULATOR 5'h09
`define MSSEM_OP_SHIFT_ROTATE 5'h0a
`define MSSEM_OP_MULTIPLY 5'h0b
`define MSSEM_OP_DIVIDE 5'h0c
`define MSSEM_OP_DOUBLE_LOAD 5'h0d
`define MSSEM_OP_DOUBLE_STORE 5'h0e
`define MSSEM_OP_ARITH_SHIFT_LEFT 5'h0f
`define MSSEM_OP_ARITH_SHIFT_RIGHT 5'h10
`define MSSEM_OP_LOGIC_SHIFT_LEFT 5'h11
`define MSSEM_OP_LOGIC_SHIFT_RIGHT 5'h12
`define MSSEM_OP_ROTATE_LEFT_LONG 5'h13
`define MSSEM_OP_ROTATE_RIGHT_LONG 5'h14
// entry microaddresses (octal values as 9-bit hex)
`define MSSEM_EA_AND 9'h048
`define MSSEM_EA_XOR 9'h050
`define MSSEM_EA_IOR 9'h058
`define MSSEM_EA_JUMP 9'h054
`define MSSEM_EA_SUBROUTINE_JUMP 9'h068
`define MSSEM_EA_INCREMENT_SKIP_ZERO 9'h078
`define MSSEM_EA_ADD_TO_ACCUMULATOR 9'h064
`define MSSEM_EA_COMPARE_ACCUMULATOR 9'h04c
`define MSSEM_EA_LOAD_ACCUMULATOR 9'h074
`define MSSEM_EA_STORE_ACCUMULATOR 9'h05c
`define MSSEM_EA_SHIFT_ROTATE_A 9'h040
`define MSSEM_EA_SHIFT_ROTATE_B 9'h044
`define MSSEM_EA_MULTIPLY 9'h088
`define MSSEM_EA_DIVIDE 9'h090
`define MSSEM_EA_DOUBLE_LOAD 9'h0c8
`define MSSEM_EA_DOUBLE_STORE 9'h0d0
`define MSSEM_EA_ARITH_SHIFT_LEFT 9'h081
`define MSSEM_EA_ARITH_SHIFT_RIGHT 9'h0a1
`define MSSEM_EA_LOGIC_SHIFT_LEFT 9'h082
`define MSSEM_EA_LOGIC_SHIFT_RIGHT 9'h0a2
`define MSSEM_EA_ROTATE_LEFT_LONG 9'h084
`define MSSEM_EA_ROTATE_RIGHT_LONG 9'h0a4
`define MSSEM_EA_DEFAULT 9'h000
// axi4-lite register byte offsets
`define MSSEM_REG_CONTROL 12'h000
`define MSSEM_REG_STATUS 12'h004
`define MSSEM_REG_ADDRESS 12'h008
// control register bit positions
`define MSSEM_CTL_ENABLE 0
`define MSSEM_CTL_PROTECT 1
// reset values and axi response codes
`define MSSEM_RST_CONTROL 2'h0
`define MSSEM_RST_ADDRESS 9'h000
`define MSSEM_RST_COUNTER 5'h00
`define MSSEM_AXI_OKAY 2'h0
`define MSSEM_AXI_SLVERR 2'h2
`endif
